// *** verilog/psct_params.svh ***
// constants for the pilot scheme coordination timers
`ifndef PSCT_PARAMS_SVH
`define PSCT_PARAMS_SVH

// ----------------------------------------------------------------
// timebase
// ----------------------------------------------------------------
`define PSCT_CLK_PERIOD_NS  10
`define PSCT_TICK_NS        1000000
`define PSCT_CYCLES_PER_MS  (`PSCT_TICK_NS / `PSCT_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// widths and fixed settings
// ----------------------------------------------------------------
`define PSCT_MS_W           16
`define PSCT_STAMP_W        32
`define PSCT_CONTACTS       5
`define PSCT_HYB_ONE_RX_MS  16'h0050
`define PSCT_HYB_TWO_RX_MS  16'h0032
`define PSCT_ZERO_MS        16'h0000

// ----------------------------------------------------------------
// contact input bit positions
// ----------------------------------------------------------------
`define PSCT_CI_FIVE        0
`define PSCT_CI_SIX         1
`define PSCT_CI_EIGHT       2
`define PSCT_CI_NINE        3
`define PSCT_CI_TEN         4

`endif

// *** verilog/psct_pkg.sv ***
// types shared by the pilot scheme coordination timers
`include "psct_params.svh"
package psct_pkg;

    // ----------------------------------------------------------------
    // scheme selection; codes 6 and 7 select nothing
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SCH_STEPPED,
        SCH_UNDERREACH,
        SCH_OVER_FIRST,
        SCH_OVER_SECOND,
        SCH_HYBRID,
        SCH_BLOCKING
    } psct_scheme_t;

    // ----------------------------------------------------------------
    // timer settings in milliseconds
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`PSCT_MS_W-1:0] tripIntegPu;
        logic [`PSCT_MS_W-1:0] reversalPu;
        logic [`PSCT_MS_W-1:0] reversalDo;
        logic [`PSCT_MS_W-1:0] breaker1Pu;
        logic [`PSCT_MS_W-1:0] breaker1Do;
        logic [`PSCT_MS_W-1:0] breaker2Pu;
        logic [`PSCT_MS_W-1:0] breaker2Do;
        logic [`PSCT_MS_W-1:0] weakInfeedPu;
        logic [`PSCT_MS_W-1:0] groundOcDo;
        logic [`PSCT_MS_W-1:0] distanceDo;
    } psct_settings_t;

    // ----------------------------------------------------------------
    // time-tagged breaker event
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                     valid;
        logic                     open;
        logic [`PSCT_STAMP_W-1:0] stamp;
    } psct_event_t;

endpackage

// *** verilog/psct_timer.sv ***
// pickup / dropout timer on the millisecond tick
`timescale 1ns/100ps
`include "psct_params.svh"
module psct_timer (
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    input  wire logic                  msTick,
    input  wire logic                  enable,
    input  wire logic                  inBit,
    input  wire logic [`PSCT_MS_W-1:0] pickupMs,
    input  wire logic [`PSCT_MS_W-1:0] dropoutMs,
    output logic                       outBit
);
    logic [`PSCT_MS_W-1:0] cnt_r;
    logic [`PSCT_MS_W-1:0] limit;

    assign limit = inBit ? pickupMs : dropoutMs;

    // ----------------------------------------------------------------
    // delay engine
    // ----------------------------------------------------------------
    // a disabled timer is held clear, so its setting never matters
    always_ff @(posedge core_clk) begin
        if (!resetn || !enable) begin
            outBit <= 1'b0;
            cnt_r  <= `PSCT_ZERO_MS;
        end else if (inBit == outBit) begin
            cnt_r <= `PSCT_ZERO_MS;              // glitch restarts the delay
        end else if (cnt_r >= limit) begin
            outBit <= inBit;
            cnt_r  <= `PSCT_ZERO_MS;
        end else if (msTick) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_zero_pass: assert property (
        enable && inBit && !outBit && pickupMs == `PSCT_ZERO_MS
            && $past(enable) |=> outBit || !enable)
        else $error("zero pickup did not pass input");
    a_pickup_cause: assert property (
        $rose(outBit) |-> $past(inBit) && $past(cnt_r) >= $past(pickupMs))
        else $error("output rose without full pickup");
    a_dropout_cause: assert property (
        $fell(outBit) && $past(enable) && $past(resetn) |-> !$past(inBit)
            && $past(cnt_r) >= $past(dropoutMs))
        else $error("output fell without full dropout");
endmodule // psct_timer

// *** verilog/psct_top.sv ***
// scheme-dependent coordination timers of the pilot tripping schemes
`timescale 1ns/100ps
`include "psct_params.svh"
module psct_top #(
    parameter int unsigned CYCLES_PER_MS = `PSCT_CYCLES_PER_MS
) (
    input  wire logic                         core_clk,
    input  wire logic                         resetn,
    input  wire logic [2:0]                   schemeSel,
    input  wire logic                         receiverCount,
    input  wire logic                         twoBreakers,
    input  wire logic                         singlePole,
    input  wire logic                         weakInfeedEnable,
    input  wire psct_pkg::psct_settings_t     settings,
    input  wire logic [`PSCT_CONTACTS-1:0]    contactIn,
    input  wire logic                         tripRequest,
    input  wire logic                         reverseFault,
    input  wire logic                         receiverIn,
    input  wire logic                         weakInfeedRequest,
    input  wire logic                         groundOcBlockIn,
    input  wire logic                         distanceBlockIn,
    output logic                              schemeValid,
    output logic                              pilotTrip,
    output logic                              reversalBlock,
    output logic                              keyTransmitter,
    output logic                              breakerOpen,
    output psct_pkg::psct_event_t             breakerEvent,
    output logic [`PSCT_MS_W-1:0]             hybridRxPickupMs,
    output logic                              hybridReceive,
    output logic                              weakInfeedTrip,
    output logic                              groundOcBlock,
    output logic                              zone4Block
);
    psct_pkg::psct_scheme_t  scheme;
    logic                    isStepped;
    logic                    isUnder;
    logic                    isOverFirst;
    logic                    isOverSecond;
    logic                    isHybrid;
    logic                    isBlocking;
    logic [31:0]             divCnt_r;
    logic                    msTick_r;
    logic [`PSCT_STAMP_W-1:0] msStamp_r;
    logic [`PSCT_CONTACTS-1:0] sync1_r;
    logic [`PSCT_CONTACTS-1:0] sync2_r;
    logic [`PSCT_CONTACTS-1:0] sync3_r;
    logic [`PSCT_CONTACTS-1:0] contact_r;
    logic                    bkr1Raw;
    logic                    bkr1Out;
    logic                    bkr2Out;
    logic                    bkrCombined;
    logic                    integIn;
    logic                    revEnable;
    logic [`PSCT_MS_W-1:0]   revPu;
    logic [`PSCT_MS_W-1:0]   revDo;
    logic                    blockFamily;

    // ----------------------------------------------------------------
    // scheme decode
    // ----------------------------------------------------------------
    // only one scheme can decode true; unused codes disable every timer
    assign scheme       = psct_pkg::psct_scheme_t'(schemeSel);
    assign schemeValid  = schemeSel <= 3'(psct_pkg::SCH_BLOCKING);
    assign isStepped    = scheme == psct_pkg::SCH_STEPPED;
    assign isUnder      = scheme == psct_pkg::SCH_UNDERREACH;
    assign isOverFirst  = scheme == psct_pkg::SCH_OVER_FIRST;
    assign isOverSecond = scheme == psct_pkg::SCH_OVER_SECOND;
    assign isHybrid     = scheme == psct_pkg::SCH_HYBRID;
    assign isBlocking   = scheme == psct_pkg::SCH_BLOCKING;
    assign blockFamily  = isBlocking || isHybrid || isOverSecond;

    // ----------------------------------------------------------------
    // millisecond timebase
    // ----------------------------------------------------------------
    // one shared tick keeps all timers in step at 1 ms resolution
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            divCnt_r <= 32'h0000_0000;
            msTick_r <= 1'b0;
        end else if (divCnt_r >= 32'(CYCLES_PER_MS - 1)) begin
            divCnt_r <= 32'h0000_0000;
            msTick_r <= 1'b1;
        end else begin
            divCnt_r <= divCnt_r + 32'h0000_0001;
            msTick_r <= 1'b0;
        end
    end

    // free-running millisecond stamp for event tagging
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            msStamp_r <= 32'h0000_0000;
        end else if (msTick_r) begin
            msStamp_r <= msStamp_r + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // contact input synchronisers
    // ----------------------------------------------------------------
    // a bit changes only when stages two and three agree, so one
    // metastable sample cannot flip the breaker state
    for (genvar i = 0; i < `PSCT_CONTACTS; i++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (!resetn) begin
                sync1_r[i]   <= 1'b0;
                sync2_r[i]   <= 1'b0;
                sync3_r[i]   <= 1'b0;
                contact_r[i] <= 1'b0;
            end else begin
                sync1_r[i] <= contactIn[i];
                sync2_r[i] <= sync1_r[i];
                sync3_r[i] <= sync2_r[i];
                if (sync2_r[i] == sync3_r[i]) begin
                    contact_r[i] <= sync3_r[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // breaker auxiliary-contact timers
    // ----------------------------------------------------------------
    // single-pole: breaker open only when all three phase contacts say so
    assign bkr1Raw = singlePole ?
        (contact_r[`PSCT_CI_EIGHT] && contact_r[`PSCT_CI_NINE]
            && contact_r[`PSCT_CI_TEN])
        : contact_r[`PSCT_CI_FIVE];

    psct_timer u_breaker1_aux_timer (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .msTick    (msTick_r),
        .enable    (schemeValid),
        .inBit     (bkr1Raw),
        .pickupMs  (settings.breaker1Pu),
        .dropoutMs (settings.breaker1Do),
        .outBit    (bkr1Out)
    );

    psct_timer u_breaker2_aux_timer (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .msTick    (msTick_r),
        .enable    (schemeValid && twoBreakers),
        .inBit     (contact_r[`PSCT_CI_SIX]),
        .pickupMs  (settings.breaker2Pu),
        .dropoutMs (settings.breaker2Do),
        .outBit    (bkr2Out)
    );

    assign bkrCombined = twoBreakers ? (bkr1Out && bkr2Out) : bkr1Out;

    // registered breaker state and event tag
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            breakerOpen  <= 1'b0;
            breakerEvent <= '0;
        end else begin
            breakerOpen        <= bkrCombined;
            breakerEvent.valid <= bkrCombined != breakerOpen;
            if (bkrCombined != breakerOpen) begin
                breakerEvent.open  <= bkrCombined;
                breakerEvent.stamp <= msStamp_r;
            end
        end
    end

    // blocking and hybrid schemes use the breaker only for events
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            keyTransmitter <= 1'b0;
        end else begin
            keyTransmitter <= bkrCombined
                && (isOverFirst || isOverSecond || isUnder);
        end
    end

    // ----------------------------------------------------------------
    // reversal coordination and trip integrator
    // ----------------------------------------------------------------
    // underreach zone-1 keying has no reversal race, so no delay at all
    assign revEnable = isOverFirst || isUnder;
    assign revPu     = isUnder ? `PSCT_ZERO_MS : settings.reversalPu;
    assign revDo     = isUnder ? `PSCT_ZERO_MS : settings.reversalDo;

    psct_timer u_reversal_coord_timer (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .msTick    (msTick_r),
        .enable    (revEnable),
        .inBit     (reverseFault),
        .pickupMs  (revPu),
        .dropoutMs (revDo),
        .outBit    (reversalBlock)
    );

    // in the first overreach scheme only, a reversal seen first holds the permissive trip off
    assign integIn = tripRequest && !(isOverFirst && reversalBlock);

    psct_timer u_trip_integrator_timer (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .msTick    (msTick_r),
        .enable    (schemeValid && !isStepped),
        .inBit     (integIn),
        .pickupMs  (settings.tripIntegPu),
        .dropoutMs (`PSCT_ZERO_MS),
        .outBit    (pilotTrip)
    );

    // ----------------------------------------------------------------
    // hybrid receive and weak infeed
    // ----------------------------------------------------------------
    assign hybridRxPickupMs = receiverCount ?
        `PSCT_HYB_TWO_RX_MS : `PSCT_HYB_ONE_RX_MS;

    psct_timer u_hybrid_receive_timer (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .msTick    (msTick_r),
        .enable    (isHybrid),
        .inBit     (receiverIn),
        .pickupMs  (hybridRxPickupMs),
        .dropoutMs (`PSCT_ZERO_MS),
        .outBit    (hybridReceive)
    );

    // short receiver bursts during weak faults die inside the pickup
    psct_timer u_weak_infeed_trip_timer (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .msTick    (msTick_r),
        .enable    (schemeValid && weakInfeedEnable),
        .inBit     (weakInfeedRequest),
        .pickupMs  (settings.weakInfeedPu),
        .dropoutMs (`PSCT_ZERO_MS),
        .outBit    (weakInfeedTrip)
    );

    // ----------------------------------------------------------------
    // transient blocking extension
    // ----------------------------------------------------------------
    psct_timer u_ground_overcurrent_block_timer (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .msTick    (msTick_r),
        .enable    (blockFamily),
        .inBit     (groundOcBlockIn),
        .pickupMs  (`PSCT_ZERO_MS),
        .dropoutMs (settings.groundOcDo),
        .outBit    (groundOcBlock)
    );

    psct_timer u_distance_block_timer (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .msTick    (msTick_r),
        .enable    (blockFamily),
        .inBit     (distanceBlockIn),
        .pickupMs  (`PSCT_ZERO_MS),
        .dropoutMs (settings.distanceDo),
        .outBit    (zone4Block)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_breaker_moves;
        bkrCombined != breakerOpen;
    endsequence
    sequence s_event_out;
        breakerEvent.valid && breakerEvent.open == breakerOpen
            && breakerEvent.stamp == $past(msStamp_r);
    endsequence

    a_event_tag_out: assert property (
        s_breaker_moves |=> s_event_out)
        else $error("breaker change gave no tagged event");
    a_key_blocked: assert property (
        $past(isBlocking || isHybrid) |-> !keyTransmitter)
        else $error("transmitter keyed in blocking family");
    a_key_on_open: assert property (
        (isOverFirst || isOverSecond || isUnder) && bkrCombined
            ##1 $stable(scheme) |-> keyTransmitter)
        else $error("open breaker did not key transmitter");
    a_two_bkr_and: assert property (
        twoBreakers && bkr1Out && !bkr2Out |=> !breakerOpen)
        else $error("two breakers not combined by AND");
    a_wi_disabled: assert property (
        !weakInfeedEnable |=> !weakInfeedTrip)
        else $error("weak infeed trip while disabled");
    a_hyb_pickup: assert property (
        hybridRxPickupMs == (receiverCount ? 16'h0032 : 16'h0050))
        else $error("hybrid receive pickup wrong");
    a_rev_unused: assert property (
        !(isOverFirst || isUnder) |=> !reversalBlock)
        else $error("reversal timer active in wrong scheme");
    a_gdoc_unused: assert property (
        isStepped || isOverFirst |=> !groundOcBlock && !zone4Block)
        else $error("blocking timers active in wrong scheme");
    a_reversal_holds: assert property (
        isOverFirst && reversalBlock && !pilotTrip |=> !pilotTrip)
        else $error("pilot trip passed during reversal block");
    a_under_nodelay: assert property (
        isUnder && reverseFault && !reversalBlock
            |=> reversalBlock)
        else $error("reversal delay present in underreach scheme");
endmodule // psct_top

// *** dv/psct_far_end.sv ***
// far-end model: breaker b-contacts and pilot channel receiver
`timescale 1ns/100ps
`include "psct_params.svh"
module psct_far_end (
    input  wire logic                     core_clk,
    input  wire logic                     brk1Open,
    input  wire logic                     brk2Open,
    input  wire logic                     singlePole,
    input  wire logic                     remoteKey,
    output logic [`PSCT_CONTACTS-1:0]     contactIn = '0,
    output logic                          receiverIn = 1'b0
);
    // contacts move on the clock so waits stay countable in cycles;
    // unwired inputs read as a closed pole, not as a stale level
    always @(posedge core_clk) begin
        contactIn <= '0;
        if (singlePole) begin
            contactIn[`PSCT_CI_EIGHT] <= brk1Open;
            contactIn[`PSCT_CI_NINE]  <= brk1Open;
            contactIn[`PSCT_CI_TEN]   <= brk1Open;
        end else begin
            contactIn[`PSCT_CI_FIVE]  <= brk1Open;
            contactIn[`PSCT_CI_SIX]   <= brk2Open;
        end
        receiverIn <= remoteKey;
    end
endmodule // psct_far_end

// *** dv/tb.sv ***
// self-checking bench for the pilot scheme coordination timers
`timescale 1ns/100ps
`include "psct_params.svh"
`define CHK(nm, ex, got) begin \
    checked++; \
    if ((got) !== (ex)) begin \
        numErrors++; \
        $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module tb;
    localparam int unsigned CPM = 10; // short millisecond keeps the run small
    logic                     core_clk = 1'b0;
    logic                     resetn = 1'b0;
    logic [2:0]               schemeSel = 3'h2;
    logic                     receiverCount = 1'b0;
    logic                     twoBreakers = 1'b0;
    logic                     singlePole = 1'b0;
    logic                     weakInfeedEnable = 1'b0;
    logic                     tripRequest = 1'b0;
    logic                     reverseFault = 1'b0;
    logic                     weakInfeedRequest = 1'b0;
    logic                     groundOcBlockIn = 1'b0;
    logic                     distanceBlockIn = 1'b0;
    logic                     brk1Open = 1'b0;
    logic                     brk2Open = 1'b0;
    logic                     remoteKey = 1'b0;
    logic [`PSCT_CONTACTS-1:0] contactIn;
    logic                     receiverIn;
    logic                     schemeValid, pilotTrip, reversalBlock;
    logic                     keyTransmitter, breakerOpen, hybridReceive;
    logic                     weakInfeedTrip, groundOcBlock, zone4Block;
    logic [`PSCT_MS_W-1:0]    hybridRxPickupMs;
    psct_pkg::psct_event_t    breakerEvent;
    logic                     evOpen;
    logic [`PSCT_STAMP_W-1:0] openStamp, closeStamp;
    int                       evCount = 0;
    int                       numErrors = 0;
    int                       checked = 0;
    logic [`PSCT_MS_W-1:0]    expPickup;
    // parallel-line coordination with a channel that releases within a
    // cycle; plain three-pole line block dropouts; weak infeed pickup kept
    // below the hybrid pickup
    psct_pkg::psct_settings_t settings = {
        16'h0004, 16'h000D, 16'h0000,
        16'h0002, 16'h0003, 16'h0001, 16'h0001,
        16'h0002,
        16'h001E,
        16'h001E};

    always #5 core_clk = ~core_clk;

    psct_top #(.CYCLES_PER_MS(CPM)) i_dut (.core_clk(core_clk),
        .resetn(resetn), .schemeSel(schemeSel),
        .receiverCount(receiverCount), .twoBreakers(twoBreakers),
        .singlePole(singlePole), .weakInfeedEnable(weakInfeedEnable),
        .settings(settings), .contactIn(contactIn),
        .tripRequest(tripRequest), .reverseFault(reverseFault),
        .receiverIn(receiverIn), .weakInfeedRequest(weakInfeedRequest),
        .groundOcBlockIn(groundOcBlockIn), .distanceBlockIn(distanceBlockIn),
        .schemeValid(schemeValid), .pilotTrip(pilotTrip),
        .reversalBlock(reversalBlock), .keyTransmitter(keyTransmitter),
        .breakerOpen(breakerOpen), .breakerEvent(breakerEvent),
        .hybridRxPickupMs(hybridRxPickupMs), .hybridReceive(hybridReceive),
        .weakInfeedTrip(weakInfeedTrip), .groundOcBlock(groundOcBlock),
        .zone4Block(zone4Block));

    psct_far_end i_far (.core_clk(core_clk), .brk1Open(brk1Open),
        .brk2Open(brk2Open), .singlePole(singlePole), .remoteKey(remoteKey),
        .contactIn(contactIn), .receiverIn(receiverIn));

    // event pulse lasts one cycle, so it is caught on every edge
    always @(posedge core_clk) if (breakerEvent.valid === 1'b1) begin
        evCount++;
        evOpen = breakerEvent.open;
        if (evOpen) openStamp = breakerEvent.stamp;
        else closeStamp = breakerEvent.stamp;
    end

    task automatic ms(input int n);
        repeat (n * CPM) @(posedge core_clk);
        #1;
    endtask

    task automatic tally_and_finish;
        if (numErrors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // test sequence
    // --------------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK("breakerOpen", 1'b0, breakerOpen)
        for (int s = 0; s < 8; s++) begin
            @(posedge core_clk) schemeSel <= 3'(s);
            @(posedge core_clk);
            #1;
            `CHK("schemeValid", (s < 6), schemeValid)
        end
        // hybrid receive pickup follows the receiver count
        @(posedge core_clk) schemeSel <= 3'h4;
        for (int r = 0; r < 2; r++) begin
            @(posedge core_clk) receiverCount <= r[0];
            remoteKey <= 1'b1;
            expPickup = r ? 16'h0032 : 16'h0050;
            ms(r ? 48 : 78);
            `CHK("hybridRxPickupMs", expPickup, hybridRxPickupMs)
            `CHK("hybridReceive", 1'b0, hybridReceive)
            ms(4);
            `CHK("hybridReceive", 1'b1, hybridReceive)
            @(posedge core_clk) remoteKey <= 1'b0;
            ms(2);
        end
        @(posedge core_clk) weakInfeedRequest <= 1'b1;
        ms(5);
        `CHK("weakInfeedTrip", 1'b0, weakInfeedTrip)
        @(posedge core_clk) weakInfeedEnable <= 1'b1;
        ms(1);
        `CHK("weakInfeedTrip", 1'b0, weakInfeedTrip)
        ms(3);
        `CHK("weakInfeedTrip", 1'b1, weakInfeedTrip)
        @(posedge core_clk) weakInfeedRequest <= 1'b0;
        weakInfeedEnable <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            @(posedge core_clk) schemeSel <= 3'(s);
            reverseFault <= 1'b1;
            repeat (2) @(posedge core_clk);
            #1;
            `CHK("reversalBlock", (s == 1), reversalBlock)
            ms(15);
            `CHK("reversalBlock", (s != 3), reversalBlock)
            @(posedge core_clk) reverseFault <= 1'b0;
            ms(5);
        end
        // pilot trip held back while reversal blocking stands
        @(posedge core_clk) schemeSel <= 3'h2;
        reverseFault <= 1'b1;
        ms(15);
        @(posedge core_clk) tripRequest <= 1'b1;
        ms(5);
        `CHK("pilotTrip", 1'b0, pilotTrip)
        @(posedge core_clk) reverseFault <= 1'b0;
        ms(3);
        `CHK("pilotTrip", 1'b0, pilotTrip)
        ms(3);
        `CHK("pilotTrip", 1'b1, pilotTrip)
        @(posedge core_clk) tripRequest <= 1'b0;
        for (int s = 0; s < 6; s++) begin
            @(posedge core_clk) schemeSel <= 3'(s);
            groundOcBlockIn <= 1'b1;
            distanceBlockIn <= 1'b1;
            ms(1);
            @(posedge core_clk) groundOcBlockIn <= 1'b0;
            distanceBlockIn <= 1'b0;
            ms(28);
            `CHK("groundOcBlock", (s >= 3), groundOcBlock)
            `CHK("zone4Block", (s >= 3), zone4Block)
            ms(4);
            `CHK("groundOcBlock", 1'b0, groundOcBlock)
            `CHK("zone4Block", 1'b0, zone4Block)
        end
        for (int s = 0; s < 6; s++) begin
            @(posedge core_clk) schemeSel <= 3'(s);
            brk1Open <= 1'b1;
            ms(1);
            `CHK("breakerOpen", 1'b0, breakerOpen)
            ms(3);
            `CHK("breakerOpen", 1'b1, breakerOpen)
            `CHK("keyTx", (s > 0 && s < 4), keyTransmitter)
            `CHK("eventOpen", 1'b1, evOpen)
            @(posedge core_clk) brk1Open <= 1'b0;
            ms(2);
            `CHK("breakerOpen", 1'b1, breakerOpen)
            ms(4);
            `CHK("breakerOpen", 1'b0, breakerOpen)
            `CHK("eventOpen", 1'b0, evOpen)
        end
        `CHK("eventCount", 12, evCount)
        `CHK("stampOrder", 1'b1, closeStamp > openStamp)
        @(posedge core_clk) twoBreakers <= 1'b1;
        brk1Open <= 1'b1;
        ms(4);
        `CHK("breakerOpen", 1'b0, breakerOpen)
        @(posedge core_clk) brk2Open <= 1'b1;
        ms(4);
        `CHK("breakerOpen", 1'b1, breakerOpen)
        @(posedge core_clk) twoBreakers <= 1'b0;
        singlePole <= 1'b1;
        brk2Open <= 1'b0;
        ms(4);
        `CHK("breakerOpen", 1'b1, breakerOpen)
        tally_and_finish();
    end

    // watchdog well beyond the expected run
    initial begin
        #200000;
        numErrors++;
        tally_and_finish();
    end
endmodule // tb
